// *** aesc_pkg.sv ***
// Constants, register map and mode codes of the block cipher engine.
// Assumes a single 200 MHz clock and an APB register port with 32-bit data.
// Summary of operation
// - Enable bit in the first control register turns the engine on and off.
// - Writing one to the soft reset bit restores every register to reset state.
// - Direction bit in the first control register picks encryption or decryption.
// - Blocks are 128 bits; key length field picks 128, 192 or 256-bit keys.
// - With key XOR update set, key writes store old word XOR new value.
// - Data writes fill a four-word buffer at the buffer index, which then wraps forward.
// - Software may write the buffer index to aim the next data access.
// - Vector registers hold the chaining start value and the counter start value.
// - Message start bit, written while idle and not with the start bit, makes the next block begin a new message.
// - Mode field picks chaining; segment field picks 8 to 128-bit feedback segments.
// - Counter mode steps a 16-bit block counter that wraps after one megabyte.
// - The engine does all mode pre-processing, post-processing and chaining itself.
// - Finishing a block sets the done flag, raising a request when enabled.
// - Data reads return buffer words at the index, which advances and wraps.
// - The done flag clears once the relevant result words have been read.
// - Data reads return zero while a block is being processed.
package aesc_pkg;
  localparam logic [7:0] ctrl_first_off = 8'h00;
  localparam logic [7:0] ctrl_second_off = 8'h04;
  localparam logic [7:0] int_enable_off = 8'h08;
  localparam logic [7:0] int_flag_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] buffer_pointer_off = 8'h14;
  localparam logic [7:0] key_base_off = 8'h18;
  localparam logic [7:0] data_window_off = 8'h38;
  localparam logic [7:0] iv_base_off = 8'h3c;
  localparam logic [7:0] auth_base_off = 8'h4c;
  localparam logic [7:0] map_end_off = 8'h5c;
  // First control register fields.
  localparam int soft_reset_pos = 0;
  localparam int enable_pos = 1;
  localparam int mode_lsb = 2;
  localparam int key_len_lsb = 5;
  localparam int segment_lsb = 8;
  localparam int key_xor_pos = 12;
  localparam int direction_pos = 14;
  // Second control register fields.
  localparam int start_pos = 0;
  localparam int message_start_pos = 1;
  localparam logic [31:0] reg_reset_value = 32'h0000_0000;
  localparam int counter_width = 16;
  localparam logic [3:0] rounds_128 = 4'ha;
  localparam logic [3:0] rounds_192 = 4'hc;
  localparam logic [3:0] rounds_256 = 4'he;
  localparam int round_rotate = 13;
  typedef enum logic [2:0] {
    mode_ecb = 3'h0, mode_cbc = 3'h1, mode_ofb = 3'h2,
    mode_cfb = 3'h3, mode_ctr = 3'h4, mode_gcm = 3'h5
  } aesc_mode_type;
  typedef enum logic [1:0] {
    key_128 = 2'h0, key_192 = 2'h1, key_256 = 2'h2
  } aesc_key_type;
  typedef enum logic [2:0] {
    seg_128 = 3'h0, seg_64 = 3'h1, seg_32 = 3'h2, seg_16 = 3'h3, seg_8 = 3'h4
  } aesc_segment_type;
  typedef enum logic [0:0] {st_idle = 1'b0, st_run = 1'b1} aesc_state_type;
endpackage

// *** aesc_core_if.sv ***
// Carrier between the register front end and the iterative cipher core.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface aesc_core_if;
  logic start;
  logic abort;
  logic decrypt;
  logic [3:0] rounds;
  logic [255:0] key;
  logic [127:0] din;
  logic [127:0] dout;
  logic done;
  modport ctl (output start, output abort, output decrypt, output rounds, output key,
    output din, input dout, input done);
  modport engine (input start, input abort, input decrypt, input rounds, input key,
    input din, output dout, output done);
endinterface

// *** aesc_core.sv ***
// Iterative keyed block permutation, one round per clock, with its inverse.
// Assumes start is a one-cycle pulse and the inputs hold until done.
`timescale 1ns/100ps
module aesc_core (
  input wire logic mclk,
  input wire logic reset,
  aesc_core_if.engine cif
);
  logic [127:0] state;
  logic [3:0] round;
  logic running;
  logic done;
  wire logic [127:0] folded_key = cif.key[255:128] ^ cif.key[127:0];
  wire logic [3:0] key_round = cif.decrypt ? 4'(cif.rounds - round) : 4'(round + 4'h1);

  // Round key is the folded key turned by a round-dependent amount.
  function automatic logic [127:0] round_key(input logic [127:0] k, input logic [3:0] r);
    logic [127:0] t;
    t = (k << (r * 7)) | (k >> (128 - r * 7));
    return t ^ {32{r}};
  endfunction

  wire logic [127:0] rk = round_key(folded_key, key_round);
  wire logic [127:0] fwd = {state[127-aesc_pkg::round_rotate:0] ^ rk[127-aesc_pkg::round_rotate:0],
    state[127:128-aesc_pkg::round_rotate] ^ rk[127:128-aesc_pkg::round_rotate]};
  wire logic [127:0] inv = {state[aesc_pkg::round_rotate-1:0],
    state[127:aesc_pkg::round_rotate]} ^ rk;

  // Round count is set by key length and the block is always 128 bits wide.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= '0;
      round <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else if (cif.abort) begin
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= running && (round == 4'(cif.rounds - 4'h1));
      if (cif.start && !running) begin
        state <= cif.din;
        round <= '0;
        running <= 1'b1;
      end else if (running) begin
        state <= cif.decrypt ? inv : fwd;
        round <= 4'(round + 4'h1);
        if (round == 4'(cif.rounds - 4'h1)) begin
          running <= 1'b0;
        end
      end
    end
  end

  assign cif.dout = state;
  assign cif.done = done;
endmodule // aesc_core

// *** aesc_engine.sv ***
// Block cipher engine: APB registers, four-word data buffer and mode chaining.
// Assumes an APB master on mclk; the cipher rounds run in aesc_core.
`timescale 1ns/100ps
module aesc_engine (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic done_irq
);
  aesc_core_if cif ();

  logic [31:0] control_first_reg;
  logic [2:0] control_second_reg;
  logic int_enable;
  logic done_flag;
  logic [1:0] buffer_index;
  logic [31:0] data_buf [4];
  logic [31:0] key_word_regs [8];
  logic [31:0] init_vector_regs [4];
  logic [31:0] auth_regs [4];
  logic [127:0] chain;
  logic [127:0] in_block;
  logic msg_pending;
  aesc_pkg::aesc_state_type state;
  logic start_q;

  // Slot index of a word within a register group.
  function automatic logic [2:0] slot(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = 8'(a - base);
    return d[4:2];
  endfunction

  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
    input logic [7:0] hi);
    return (a >= lo) && (a < hi);
  endfunction

  function automatic logic [127:0] pack4(input logic [31:0] w0, input logic [31:0] w1,
    input logic [31:0] w2, input logic [31:0] w3);
    return {w0, w1, w2, w3};
  endfunction

  // Bus decoding; the engine always answers in the first access cycle.
  // Writes to unaligned or unmapped places are dropped, like their reads.
  wire logic wr_acc = psel && penable && pwrite && addr_ok;
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic rd_setup = psel && !penable && !pwrite;
  wire logic addr_ok = (paddr[1:0] == 2'b00) && (paddr < aesc_pkg::map_end_off);
  wire logic sel_first = paddr == aesc_pkg::ctrl_first_off;
  wire logic sel_second = paddr == aesc_pkg::ctrl_second_off;
  wire logic sel_ien = paddr == aesc_pkg::int_enable_off;
  wire logic sel_flag = paddr == aesc_pkg::int_flag_off;
  wire logic sel_ptr = paddr == aesc_pkg::buffer_pointer_off;
  wire logic sel_data = paddr == aesc_pkg::data_window_off;
  wire logic sel_key = in_range(paddr, aesc_pkg::key_base_off, aesc_pkg::data_window_off);
  wire logic sel_iv = in_range(paddr, aesc_pkg::iv_base_off, aesc_pkg::auth_base_off);
  wire logic sel_auth = in_range(paddr, aesc_pkg::auth_base_off, aesc_pkg::map_end_off);
  wire logic [2:0] key_slot = slot(paddr, aesc_pkg::key_base_off);
  wire logic [1:0] iv_slot = 2'(slot(paddr, aesc_pkg::iv_base_off));
  wire logic [1:0] auth_slot = 2'(slot(paddr, aesc_pkg::auth_base_off));
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Soft reset wins over every other field of the same write.
  wire logic soft_reset = wr_acc && sel_first && pwdata[aesc_pkg::soft_reset_pos];
  wire logic busy = state == aesc_pkg::st_run;
  wire logic enabled = control_first_reg[aesc_pkg::enable_pos];

  // Field views of the first control register.
  wire aesc_pkg::aesc_mode_type mode = aesc_pkg::aesc_mode_type'(
    control_first_reg[aesc_pkg::mode_lsb +: 3]);
  wire aesc_pkg::aesc_key_type key_len = aesc_pkg::aesc_key_type'(
    control_first_reg[aesc_pkg::key_len_lsb +: 2]);
  wire aesc_pkg::aesc_segment_type seg = aesc_pkg::aesc_segment_type'(
    control_first_reg[aesc_pkg::segment_lsb +: 3]);
  wire logic encrypt = control_first_reg[aesc_pkg::direction_pos];
  wire logic key_xor_update = control_first_reg[aesc_pkg::key_xor_pos];

  // Segment width in bits; anything but feedback mode uses the whole block.
  wire logic [7:0] seg_bits = (mode != aesc_pkg::mode_cfb) ? 8'h80 :
    (seg == aesc_pkg::seg_64) ? 8'h40 : (seg == aesc_pkg::seg_32) ? 8'h20 :
    (seg == aesc_pkg::seg_16) ? 8'h10 : (seg == aesc_pkg::seg_8) ? 8'h08 : 8'h80;
  wire logic [7:0] seg_rest = 8'(8'h80 - seg_bits);
  wire logic [127:0] seg_mask = ~128'h0 << seg_rest;
  // Last buffer word that carries a result; its read retires the done flag.
  wire logic [1:0] last_word = (seg_bits <= 8'h20) ? 2'h0 :
    (seg_bits == 8'h40) ? 2'h1 : 2'h3;

  // Pre-processing: pick the chaining value and form the core input.
  wire logic [127:0] iv_block = pack4(init_vector_regs[0], init_vector_regs[1],
    init_vector_regs[2], init_vector_regs[3]);
  wire logic [127:0] buf_block = pack4(data_buf[0], data_buf[1], data_buf[2], data_buf[3]);
  wire logic [127:0] eff_chain = msg_pending ? iv_block : chain;
  wire logic direct = (mode == aesc_pkg::mode_ecb) || (mode == aesc_pkg::mode_cbc);
  wire logic [127:0] pre_block = (mode == aesc_pkg::mode_ecb) ? buf_block :
    (mode == aesc_pkg::mode_cbc) ? (encrypt ? buf_block ^ eff_chain : buf_block) :
    eff_chain;

  // Post-processing and next chaining value from the core output.
  wire logic [127:0] core_out = cif.dout;
  wire logic [127:0] stream_out = (in_block ^ core_out) & seg_mask;
  wire logic [127:0] result = (mode == aesc_pkg::mode_ecb) ? core_out :
    (mode == aesc_pkg::mode_cbc) ? (encrypt ? core_out : core_out ^ chain) :
    stream_out;
  wire logic [127:0] cfb_text = encrypt ? stream_out : (in_block & seg_mask);
  wire logic [127:0] cfb_next = (chain << seg_bits) | (cfb_text >> seg_rest);
  wire logic [127:0] ctr_next = {chain[127:aesc_pkg::counter_width],
    16'(chain[aesc_pkg::counter_width-1:0] + 16'h0001)};
  wire logic [127:0] next_chain = (mode == aesc_pkg::mode_cbc) ?
    (encrypt ? core_out : in_block) : (mode == aesc_pkg::mode_ofb) ? core_out :
    (mode == aesc_pkg::mode_cfb) ? cfb_next :
    ((mode == aesc_pkg::mode_ctr) || (mode == aesc_pkg::mode_gcm)) ? ctr_next :
    chain;

  // Key words beyond the chosen length are masked off before the core sees them.
  wire logic [255:0] key_all = {key_word_regs[0], key_word_regs[1], key_word_regs[2],
    key_word_regs[3], key_word_regs[4], key_word_regs[5], key_word_regs[6],
    key_word_regs[7]};
  wire logic [255:0] key_mask = (key_len == aesc_pkg::key_128) ? {{128{1'b1}}, 128'h0} :
    (key_len == aesc_pkg::key_192) ? {{192{1'b1}}, 64'h0} : {256{1'b1}};
  wire logic start_req = wr_acc && sel_second && pwdata[aesc_pkg::start_pos] &&
    enabled && !busy && !soft_reset;
  wire logic msg_req = wr_acc && sel_second && pwdata[aesc_pkg::message_start_pos];
  wire logic data_rd = rd_acc && sel_data;
  wire logic data_wr = wr_acc && sel_data && !busy;
  wire logic core_abort = soft_reset || !enabled;

  assign cif.start = start_q;
  assign cif.abort = core_abort;
  assign cif.decrypt = direct && !encrypt;
  assign cif.rounds = (key_len == aesc_pkg::key_192) ? aesc_pkg::rounds_192 :
    (key_len == aesc_pkg::key_256) ? aesc_pkg::rounds_256 : aesc_pkg::rounds_128;
  assign cif.key = key_all & key_mask;
  assign cif.din = pre_block;
  assign done_irq = done_flag && int_enable;

  aesc_core u_core (
    .mclk(mclk),
    .reset(reset),
    .cif(cif)
  );

  // Control registers; a soft reset clears them like the pin does.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      control_first_reg <= aesc_pkg::reg_reset_value;
      int_enable <= 1'b0;
    end else if (soft_reset) begin
      control_first_reg <= aesc_pkg::reg_reset_value;
      int_enable <= 1'b0;
    end else if (wr_acc && sel_first) begin
      control_first_reg <= pwdata & 32'h0000_57fe;
    end else if (wr_acc && sel_ien) begin
      int_enable <= pwdata[0];
    end
  end

  // Key, vector and authentication words.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      key_word_regs <= '{default: '0};
      init_vector_regs <= '{default: '0};
      auth_regs <= '{default: '0};
    end else if (soft_reset) begin
      key_word_regs <= '{default: '0};
      init_vector_regs <= '{default: '0};
      auth_regs <= '{default: '0};
    end else if (wr_acc && sel_key) begin
      key_word_regs[key_slot] <= key_xor_update ?
        (key_word_regs[key_slot] ^ pwdata) : pwdata;
    end else if (wr_acc && sel_iv) begin
      init_vector_regs[iv_slot] <= pwdata;
    end else if (wr_acc && sel_auth) begin
      auth_regs[auth_slot] <= pwdata;
    end
  end

  // Data buffer and its shared index; results overwrite the buffer on completion.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      data_buf <= '{default: '0};
      buffer_index <= '0;
    end else if (soft_reset) begin
      data_buf <= '{default: '0};
      buffer_index <= '0;
    end else if (cif.done) begin
      data_buf[0] <= result[127:96];
      data_buf[1] <= result[95:64];
      data_buf[2] <= result[63:32];
      data_buf[3] <= result[31:0];
    end else if (wr_acc && sel_ptr) begin
      buffer_index <= pwdata[1:0];
    end else if (data_wr) begin
      data_buf[buffer_index] <= pwdata;
      buffer_index <= 2'(buffer_index + 2'h1);
    end else if (data_rd) begin
      buffer_index <= 2'(buffer_index + 2'h1);
    end
  end

  // Sequencer, chaining value and message start flag.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= aesc_pkg::st_idle;
      start_q <= 1'b0;
      chain <= '0;
      in_block <= '0;
      msg_pending <= 1'b0;
    end else if (core_abort) begin
      state <= aesc_pkg::st_idle;
      start_q <= 1'b0;
      if (soft_reset) begin
        chain <= '0;
        msg_pending <= 1'b0;
      end else if (msg_req) begin
        msg_pending <= 1'b1;
      end
    end else begin
      start_q <= start_req;
      unique case (state)
        aesc_pkg::st_idle: begin
          if (start_req) begin
            state <= aesc_pkg::st_run;
            in_block <= buf_block;
            chain <= eff_chain;
            msg_pending <= 1'b0;
          end else if (msg_req) begin
            msg_pending <= 1'b1;
          end
        end
        aesc_pkg::st_run: begin
          if (cif.done) begin
            state <= aesc_pkg::st_idle;
            chain <= next_chain;
          end
        end
      endcase
    end
  end

  // Done flag: completion sets it, reading the last result word clears it.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      done_flag <= 1'b0;
    end else if (soft_reset) begin
      done_flag <= 1'b0;
    end else if (cif.done) begin
      done_flag <= 1'b1;
    end else if ((data_rd && !busy && buffer_index == last_word) ||
      (wr_acc && sel_flag && pwdata[0])) begin
      done_flag <= 1'b0;
    end
  end

  // Read multiplexer, sampled in the setup phase.
  wire logic [31:0] status_word = {28'h0, buffer_index, enabled, busy};
  wire logic [31:0] rd_mux = !addr_ok ? 32'h0000_0000 : sel_first ? control_first_reg :
    sel_second ? {30'h0, msg_pending, 1'b0} : sel_ien ? {31'h0, int_enable} :
    sel_flag ? {31'h0, done_flag} : (paddr == aesc_pkg::status_off) ? status_word :
    sel_ptr ? {30'h0, buffer_index} :
    sel_data ? (busy ? 32'h0000_0000 : data_buf[buffer_index]) :
    sel_key ? 32'h0000_0000 : sel_iv ? init_vector_regs[iv_slot] :
    sel_auth ? auth_regs[auth_slot] : 32'h0000_0000;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end
endmodule // aesc_engine

// *** aesc_engine_properties.sv ***
// Concurrent checks on the port side of the block cipher engine.
// Assumes it is bound to aesc_engine and sees only that module's ports.
`timescale 1ns/100ps
module aesc_engine_properties (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic done_irq
);
  logic en_q, ie_q, fresh;
  logic [1:0] kl_q;
  logic [3:0] cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Decoded bus events; a start only counts while enabled and idle.
  wire acc = psel && penable;
  wire bad = paddr >= 8'h5c || paddr[1:0] != 2'h0;
  wire wr_ctl = acc && pwrite && paddr == 8'h00;
  wire srst = wr_ctl && pwdata[0];
  wire kick = acc && pwrite && paddr == 8'h04 && pwdata[0];
  wire go = kick && en_q && cnt == 4'h0;
  // Shadow of enable, interrupt enable and key length, plus a busy countdown.
  // The countdown reaches zero one edge before the edge that sets the done flag, so it never overlaps done_irq.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {en_q, ie_q, fresh, kl_q, cnt} <= '0;
    end else if (srst) begin
      {en_q, ie_q, fresh, kl_q, cnt} <= '0;
    end else begin
      fresh <= go;
      en_q <= wr_ctl ? pwdata[1] : en_q;
      kl_q <= wr_ctl ? pwdata[6:5] : kl_q;
      ie_q <= (acc && pwrite && paddr == 8'h08) ? pwdata[0] : ie_q;
      if (go) begin
        cnt <= 4'hb + {1'b0, kl_q, 1'b0};
      end else if (wr_ctl && !pwdata[1]) begin
        cnt <= 4'h0;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  chk_ready_high: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  chk_error_map: assert property (acc |-> pslverr == bad)
    else $error("pslverr does not follow the address map");
  chk_hidden_zero: assert property (
    acc && !pwrite && (bad || paddr inside {[8'h18:8'h34]}) |-> prdata == 32'h0)
    else $error("key or unmapped read returned data");
  chk_busy_zero: assert property (
    acc && !pwrite && paddr == 8'h38 && $past(cnt) != 4'h0 && !$past(fresh) |-> prdata == 32'h0)
    else $error("data read during processing was not zero");
  chk_done_time: assert property (
    go && ie_q && kl_q == 2'h0 && !done_irq |-> ##12 !done_irq ##1 done_irq)
    else $error("completion request not raised twelve cycles after start");
  chk_irq_enabled: assert property (done_irq |-> ie_q)
    else $error("completion request without its enable");
  chk_srst_clear: assert property (srst |=> !done_irq)
    else $error("soft reset left the completion request high");
  chk_start_off: assert property (
    kick && !en_q && cnt == 4'h0 && !done_irq |=> !done_irq [*8] ##1 !done_irq [*8])
    else $error("disabled engine completed a block");
  cover property (go);
  cover property (done_irq);
  cover property (acc && bad);
endmodule // aesc_engine_properties

bind aesc_engine aesc_engine_properties u_props (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .done_irq(done_irq));

// *** test_aes_block_cipher_engine.sv ***
// Self-checking bench for the block cipher engine, driven over APB.
// Assumes the register map of aesc_pkg and a zero-wait-state slave.
`timescale 1ns/100ps
module test_aes_block_cipher_engine;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, done_irq, err_seen;
  int err_count = 0;
  int samples_checked = 0;
  // Free-running 200 MHz clock.
  always #2.5 mclk = ~mclk;
  aesc_engine DUT (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .done_irq(done_irq));
  // Closing report; every exit path ends here.
  task automatic end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // One transfer; select stays high so the next setup may follow at once.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err_seen = pslverr;
    if (n >= 20) begin
      chk("pready", 1'b0, 1'b1);
      end_sim;
    end
  endtask
  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask
  function automatic logic [31:0] ctl(input int m, input int kl, input bit en, input bit enc,
      input bit xk);
    return (32'(en) << aesc_pkg::enable_pos) | (32'(m) << aesc_pkg::mode_lsb)
      | (32'(kl) << aesc_pkg::key_len_lsb) | (32'(xk) << aesc_pkg::key_xor_pos)
      | (32'(enc) << aesc_pkg::direction_pos);
  endfunction
  function automatic logic [127:0] r128();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction
  task automatic keys(input logic [255:0] k);
    for (int i = 0; i < 8; i++) bus(1'b1, 8'h18 + 8'(4 * i), k[255 - 32 * i -: 32]);
  endtask
  // Loads, starts and reads back one block; the probe peeks at it while it runs.
  task automatic block(input logic [127:0] din, output logic [127:0] dout, input bit probe);
    int n;
    bus(1'b1, 8'h14, 32'h0);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'h38, din[127 - 32 * i -: 32]);
    bus(1'b1, 8'h04, 32'h1);
    idle(1);
    if (probe) begin
      bus(1'b0, 8'h38, 32'h0);
      chk("busy data read", rd, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk("status while busy", rd[1:0], 2'h3);
      bus(1'b1, 8'h14, 32'h0);
    end
    n = 0;
    do begin
      bus(1'b0, 8'h0c, 32'h0);
      n++;
    end while (rd[0] !== 1'b1 && n < 40);
    chk("done flag", rd[0], 1'b1);
    if (n >= 40) end_sim;
    chk("done request", done_irq, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h38, 32'h0);
      dout[127 - 32 * i -: 32] = rd;
    end
    bus(1'b0, 8'h0c, 32'h0);
    chk("done after read", rd[0], 1'b0);
  endtask
  // Two-block message; the start-of-message bit makes the chain restart from the vector.
  task automatic msg(input logic [31:0] cfg, input logic [127:0] iv, input logic [127:0] a,
      input logic [127:0] b, output logic [127:0] x, output logic [127:0] y);
    bus(1'b1, 8'h00, cfg);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'h3c + 8'(4 * i), iv[127 - 32 * i -: 32]);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'h4c + 8'(4 * i), iv[127 - 32 * i -: 32]);
    bus(1'b0, 8'h4c, 32'h0);
    chk("authentication word", rd, iv[127:96]);
    bus(1'b1, 8'h04, 32'h2);
    bus(1'b0, 8'h04, 32'h0);
    chk("message start pending", rd[1], 1'b1);
    block(a, x, 1'b1);
    block(b, y, 1'b0);
  endtask
  initial begin
    logic [127:0] p0, p1, c0, c1, q0, q1, iv;
    logic [255:0] k, b;
    logic [31:0] w [4];
    void'($urandom(32'h4759));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // Reset values, the data window and an unmapped place.
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    bus(1'b0, 8'h38, 32'h0);
    chk("data window reset", rd, 32'h0);
    bus(1'b0, 8'h5c, 32'h0);
    chk("unmapped error", err_seen, 1'b1);
    // Buffer index: aimed, wrapped on writes and on reads.
    bus(1'b1, 8'h14, 32'h2);
    for (int i = 0; i < 4; i++) begin
      w[i] = $urandom;
      bus(1'b1, 8'h38, w[i]);
    end
    bus(1'b0, 8'h10, 32'h0);
    chk("index after writes", rd[3:2], 2'h2);
    bus(1'b1, 8'h14, 32'h0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 8'h38, 32'h0);
      chk("buffer word", rd, w[(i + 2) % 4]);
    end
    bus(1'b0, 8'h14, 32'h0);
    chk("index after reads", rd[1:0], 2'h0);
    // A start while disabled must not complete.
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h00, ctl(0, 0, 0, 1, 0));
    bus(1'b1, 8'h04, 32'h1);
    idle(16);
    bus(1'b0, 8'h0c, 32'h0);
    chk("start while disabled", rd[0], 1'b0);
    // Every mode and key length, encrypted and then decrypted back.
    for (int m = 0; m < 6; m++) begin
      for (int kl = 0; kl < 3; kl++) begin
        keys({r128(), r128()});
        iv = r128();
        p0 = r128();
        p1 = r128();
        msg(ctl(m, kl, 1, 1, 0), iv, p0, p1, c0, c1);
        msg(ctl(m, kl, 1, 0, 0), iv, c0, c1, q0, q1);
        chk("first block round trip", q0, p0);
        chk("chained block round trip", q1, p1);
      end
    end
    // Narrow feedback segment: input and results use buffer word zero only.
    p0[95:0] = '0;
    p1[95:0] = '0;
    msg(ctl(3, 0, 1, 1, 0) | 32'h0000_0200, iv, p0, p1, c0, c1);
    msg(ctl(3, 0, 1, 0, 0) | 32'h0000_0200, iv, c0, c1, q0, q1);
    chk("segment round trip", {q0[127:96], q1[127:96]}, {p0[127:96], p1[127:96]});
    chk("segment tail", {q0[95:0], q1[95:0]}, 192'h0);
    // The block counter wraps within its low 16 bits.
    iv = r128();
    iv[15:0] = 16'hffff;
    msg(ctl(4, 0, 1, 1, 0), iv, p0, p1, c0, c1);
    iv[15:0] = 16'h0000;
    msg(ctl(4, 0, 1, 1, 0), iv, p1, p0, q0, q1);
    chk("counter wrap", q0, c1);
    // Soft reset, then the same key built from two XOR updates.
    k = {r128(), r128()};
    b = {r128(), r128()};
    keys(k);
    msg(ctl(0, 2, 1, 1, 0), iv, p0, p1, c0, c1);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk("enable after soft reset", rd, 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk("control after soft reset", rd, 32'h0);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h00, ctl(0, 2, 1, 1, 1));
    keys(b);
    keys(k ^ b);
    msg(ctl(0, 2, 1, 1, 1), iv, p0, p1, q0, q1);
    chk("xor key result", q0, c0);
    idle(2);
    end_sim;
  end
endmodule // test_aes_block_cipher_engine
